/* File: logic/mcd_pkg.sv */
// ----------------------------------------------------------------------------
// Calibration datapath constants
// ----------------------------------------------------------------------------
package mcd_pkg;

  // --------------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] OFS_CUR_GAIN     = 8'h00;
  localparam logic [7:0] OFS_CHG_GAIN     = 8'h04;
  localparam logic [7:0] OFS_CELL_OFFSET  = 8'h08;
  localparam logic [7:0] OFS_DIV_OFFSET   = 8'h0C;
  localparam logic [7:0] OFS_OFFSET_CONVS = 8'h10;
  localparam logic [7:0] OFS_BOARD_OFFSET = 8'h14;
  localparam logic [7:0] OFS_INT_OFFSET   = 8'h18;
  localparam logic [7:0] OFS_INT_GAIN     = 8'h1C;
  localparam logic [7:0] OFS_INT_BASE     = 8'h20;
  localparam logic [7:0] OFS_INT_MAX_AD   = 8'h24;
  localparam logic [7:0] OFS_INT_MAX_TEMP = 8'h28;
  localparam logic [7:0] OFS_PIN_MODE     = 8'h2C;
  localparam logic [7:0] OFS_PIN_OFFSET   = 8'h30;
  localparam logic [7:0] OFS_STATUS       = 8'h3C;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int POS_PIN_THERM   = 0;
  localparam int POS_PIN_POLY    = 16;
  localparam int POS_STAT_SAT    = 0;
  localparam int POS_STAT_NOCONV = 1;

  // --------------------------------------------------------------------------
  // Values after reset, and the charge-per-current factor
  // --------------------------------------------------------------------------
  localparam logic [31:0] RST_CUR_GAIN     = 32'h40EF41F2;
  localparam logic [31:0] RST_CHG_GAIN     = 32'h4A081C6A;
  localparam logic [31:0] CHG_PER_CUR      = 32'h4891A2B4;
  localparam logic [15:0] RST_CELL_OFFSET  = 16'h0000;
  localparam logic [15:0] RST_DIV_OFFSET   = 16'h0000;
  localparam logic [15:0] RST_OFFSET_CONVS = 16'h0040;
  localparam logic [15:0] RST_BOARD_OFFSET = 16'h0000;
  localparam logic [7:0]  RST_INT_OFFSET   = 8'h00;
  localparam logic [15:0] RST_INT_GAIN     = 16'h632E;
  localparam logic [15:0] RST_INT_BASE     = 16'h0BD8;
  localparam logic [15:0] RST_INT_MAX_AD   = 16'h3FFF;
  localparam logic [15:0] RST_INT_MAX_TEMP = 16'h18EB;
  localparam logic [7:0]  RST_PIN_OFFSET   = 8'h00;

  // --------------------------------------------------------------------------
  // Fixed-point formats and pin count
  // --------------------------------------------------------------------------
  localparam int QUOT_FRAC = 16;
  localparam int OUT_FRAC  = 8;
  localparam int INT_SHIFT = 16;
  localparam int NUM_PINS  = 9;

endpackage : mcd_pkg

/* File: logic/mcd_fp_mul.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Single-precision product, normal operands only, truncating.
// ----------------------------------------------------------------------------
module mcd_fp_mul (
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  output logic      [31:0] p
);
  logic [47:0] prod;
  logic [9:0]  exp_sum;
  logic [9:0]  exp_out;
  logic [22:0] frac;

  assign prod    = {1'b1, a[22:0]} * {1'b1, b[22:0]};
  assign exp_sum = {2'b00, a[30:23]} + {2'b00, b[30:23]} + {9'h000, prod[47]};

  always_comb begin
    frac    = prod[47] ? prod[46:24] : prod[45:23];
    exp_out = exp_sum - 10'h07F;
    // Underflow and overflow clamp rather than wrap, so a bad gain stays finite.
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || exp_sum <= 10'h07F) begin
      p = 32'h00000000;
    end else if (exp_out > 10'h0FE) begin
      p = {a[31] ^ b[31], 8'hFE, 23'h7FFFFF};
    end else begin
      p = {a[31] ^ b[31], exp_out[7:0], frac};
    end
  end
endmodule : mcd_fp_mul

/* File: logic/mcd_fp_scale.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Signed fixed-point count times single-precision gain.
// ----------------------------------------------------------------------------
module mcd_fp_scale #(
  parameter int CW    = 32,
  parameter int OW    = 48,
  parameter int SHIFT = 8
) (
  input  wire logic signed [CW-1:0] count,
  input  wire logic        [31:0]   gain,
  output logic signed      [OW-1:0] result
);
  logic [CW-1:0]    mag;
  logic [CW+23:0]   prod;
  logic [127:0]     wide;
  logic [127:0]     moved;
  logic signed [11:0] sh;
  logic [OW-1:0]    low;

  assign mag  = count[CW-1] ? CW'(-count) : count;
  assign prod = mag * {1'b1, gain[22:0]};
  assign wide = 128'(prod);
  assign sh   = $signed({4'h0, gain[30:23]}) - 12'sd150 + 12'(SHIFT);

  always_comb begin
    // Bits beyond OW are dropped; the gain range keeps real results inside.
    if (sh[11]) begin
      moved = wide >> 7'(-sh);
    end else begin
      moved = wide << 7'(sh);
    end
    low = moved[OW-1:0];
    if (gain[30:23] == 8'h00) begin
      result = '0;
    end else if (count[CW-1] ^ gain[31]) begin
      result = $signed(OW'(-low));
    end else begin
      result = $signed(low);
    end
  end
endmodule : mcd_fp_scale

/* File: logic/mcd_calib.sv */
`timescale 1ns/1ps
// What this block does
// - Writing the current gain reloads charge gain as current gain times 298261.6178.
// - Coulomb-counter counts times the float charge gain give passed charge.
// - Signed cell offset, default zero, is subtracted from every cell voltage.
// - Signed divider offset is subtracted from stack, pack and load voltages.
// - Board offset is counts accumulated over a 16-bit conversion count, default 64.
// - Board offset divided by that count is subtracted from each current sample.
// - Signed 8-bit internal temperature offset, 0.1 degree units, is added.
// - Each of nine pins adds its own offset when thermistor with polynomial.
// - No pin offset for an analog-input pin or a pin without polynomial.
// - Internal temperature is raw counts times a signed 16-bit gain, default 25390.
// - A signed base offset, default 3032, is added after the gain.
// - Raw counts above a signed threshold, default 16383, report a fixed temperature.
// - That fixed temperature is a setting in 0.1 kelvin, default 6379.
// - Current is counts times a float current gain defaulting to 7.4768.
module mcd_calib (
  input  wire logic               SYS_CLK,
  input  wire logic               ARST_N,
  input  wire logic        [7:0]  AVS_ADDRESS,
  input  wire logic               AVS_READ,
  input  wire logic               AVS_WRITE,
  input  wire logic        [31:0] AVS_WRITEDATA,
  input  wire logic        [3:0]  AVS_BYTEENABLE,
  output logic             [31:0] AVS_READDATA,
  output logic                    AVS_WAITREQUEST,
  input  wire logic               CELL_IN_VALID,
  input  wire logic        [3:0]  CELL_IN_INDEX,
  input  wire logic signed [15:0] CELL_IN_MV,
  input  wire logic               DIV_IN_VALID,
  input  wire logic        [1:0]  DIV_IN_SEL,
  input  wire logic signed [15:0] DIV_IN_VOLT,
  input  wire logic               CC_IN_VALID,
  input  wire logic signed [31:0] CC_IN_COUNT,
  input  wire logic               INT_IN_VALID,
  input  wire logic signed [15:0] INT_IN_RAW,
  input  wire logic               PIN_IN_VALID,
  input  wire logic        [3:0]  PIN_IN_INDEX,
  input  wire logic signed [15:0] PIN_IN_TEMP,
  output logic                    CELL_OUT_VALID,
  output logic             [3:0]  CELL_OUT_INDEX,
  output logic signed      [16:0] CELL_OUT_MV,
  output logic                    DIV_OUT_VALID,
  output logic             [1:0]  DIV_OUT_SEL,
  output logic signed      [16:0] DIV_OUT_VOLT,
  output logic                    CC_OUT_VALID,
  output logic signed      [47:0] CC_OUT_CURRENT,
  output logic signed      [47:0] CC_OUT_CHARGE,
  output logic                    INT_OUT_VALID,
  output logic signed      [31:0] INT_OUT_TEMP,
  output logic                    INT_OUT_SATURATED,
  output logic                    PIN_OUT_VALID,
  output logic             [3:0]  PIN_OUT_INDEX,
  output logic signed      [16:0] PIN_OUT_TEMP
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                  cur_gain;
    logic [31:0]                  chg_gain;
    logic signed [15:0]           cell_offset;
    logic signed [15:0]           div_offset;
    logic [15:0]                  offset_convs;
    logic signed [15:0]           board_offset;
    logic signed [7:0]            int_offset;
    logic signed [15:0]           int_gain;
    logic signed [15:0]           int_base;
    logic signed [15:0]           int_max_ad;
    logic signed [15:0]           int_max_temp;
    logic [mcd_pkg::NUM_PINS-1:0] pin_therm;
    logic [mcd_pkg::NUM_PINS-1:0] pin_poly;
    logic [mcd_pkg::NUM_PINS-1:0][7:0] pin_offset;
    logic signed [31:0]           board_quot;
    logic                         served;
    logic [31:0]                  rdata;
    logic                         cell_valid;
    logic [3:0]                   cell_index;
    logic signed [16:0]           cell_mv;
    logic                         div_valid;
    logic [1:0]                   div_sel;
    logic signed [16:0]           div_volt;
    logic                         cc_valid;
    logic signed [47:0]           cc_current;
    logic signed [47:0]           cc_charge;
    logic                         int_valid;
    logic signed [31:0]           int_temp;
    logic                         int_sat;
    logic                         pin_valid;
    logic [3:0]                   pin_index;
    logic signed [16:0]           pin_temp;
  } mcd_state_t;

  mcd_state_t         s;
  mcd_state_t         next_s;
  logic [31:0]        chg_from_cur;
  logic signed [47:0] cur_scaled;
  logic signed [47:0] chg_scaled;
  logic signed [47:0] cc_corrected;
  logic [31:0]        quot_mag;
  logic signed [31:0] int_product;
  logic signed [31:0] int_calc;
  logic [31:0]        read_mux;
  logic [31:0]        wr_merged;
  logic               wr_hit;
  logic               pin_applies;
  logic signed [7:0]  pin_adjust;

  // --------------------------------------------------------------------------
  // Arithmetic
  // --------------------------------------------------------------------------
  // The product takes the incoming word, so the reload follows the gain being written.
  mcd_fp_mul u_chg_gain (
    .a (wr_merged),
    .b (mcd_pkg::CHG_PER_CUR),
    .p (chg_from_cur)
  );

  // The quotient stays in a register, so a new setting applies one cycle later.
  assign quot_mag = (s.offset_convs == 16'h0000) ? 32'h00000000 :
                    {(s.board_offset[15] ? 16'(-s.board_offset) : s.board_offset),
                     16'h0000} / {16'h0000, s.offset_convs};

  assign cc_corrected = (48'(CC_IN_COUNT) <<< mcd_pkg::QUOT_FRAC)
                        - 48'(s.board_quot);

  mcd_fp_scale #(
    .CW    (48),
    .OW    (48),
    .SHIFT (mcd_pkg::OUT_FRAC - mcd_pkg::QUOT_FRAC)
  ) u_current (
    .count  (cc_corrected),
    .gain   (s.cur_gain),
    .result (cur_scaled)
  );

  mcd_fp_scale #(
    .CW    (32),
    .OW    (48),
    .SHIFT (mcd_pkg::OUT_FRAC)
  ) u_charge (
    .count  (CC_IN_COUNT),
    .gain   (s.chg_gain),
    .result (chg_scaled)
  );

  assign int_product = INT_IN_RAW * s.int_gain;
  assign int_calc    = (int_product >>> mcd_pkg::INT_SHIFT)
                       + 32'(s.int_base) + 32'(s.int_offset);

  assign pin_applies = (PIN_IN_INDEX < 4'(mcd_pkg::NUM_PINS))
                       && s.pin_therm[PIN_IN_INDEX] && s.pin_poly[PIN_IN_INDEX];
  assign pin_adjust  = pin_applies ? $signed(s.pin_offset[PIN_IN_INDEX])
                                   : 8'sh00;

  // --------------------------------------------------------------------------
  // Register readback
  // --------------------------------------------------------------------------
  always_comb begin
    read_mux = 32'h00000000;
    unique case (AVS_ADDRESS)
      mcd_pkg::OFS_CUR_GAIN:     read_mux = s.cur_gain;
      mcd_pkg::OFS_CHG_GAIN:     read_mux = s.chg_gain;
      mcd_pkg::OFS_CELL_OFFSET:  read_mux = 32'(s.cell_offset);
      mcd_pkg::OFS_DIV_OFFSET:   read_mux = 32'(s.div_offset);
      mcd_pkg::OFS_OFFSET_CONVS: read_mux = {16'h0000, s.offset_convs};
      mcd_pkg::OFS_BOARD_OFFSET: read_mux = 32'(s.board_offset);
      mcd_pkg::OFS_INT_OFFSET:   read_mux = 32'(s.int_offset);
      mcd_pkg::OFS_INT_GAIN:     read_mux = 32'(s.int_gain);
      mcd_pkg::OFS_INT_BASE:     read_mux = 32'(s.int_base);
      mcd_pkg::OFS_INT_MAX_AD:   read_mux = 32'(s.int_max_ad);
      mcd_pkg::OFS_INT_MAX_TEMP: read_mux = 32'(s.int_max_temp);
      mcd_pkg::OFS_PIN_MODE: begin
        read_mux[mcd_pkg::POS_PIN_THERM +: mcd_pkg::NUM_PINS] = s.pin_therm;
        read_mux[mcd_pkg::POS_PIN_POLY +: mcd_pkg::NUM_PINS]  = s.pin_poly;
      end
      mcd_pkg::OFS_PIN_OFFSET:   read_mux = s.pin_offset[3:0];
      mcd_pkg::OFS_PIN_OFFSET + 8'h04: read_mux = s.pin_offset[7:4];
      mcd_pkg::OFS_PIN_OFFSET + 8'h08: read_mux = {24'h000000, s.pin_offset[8]};
      mcd_pkg::OFS_STATUS: begin
        read_mux[mcd_pkg::POS_STAT_SAT]    = s.int_sat;
        read_mux[mcd_pkg::POS_STAT_NOCONV] = (s.offset_convs == 16'h0000);
      end
      default: read_mux = 32'h00000000;
    endcase
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++) begin
      if (be[k]) begin
        r[8*k +: 8] = wd[8*k +: 8];
      end
    end
    return r;
  endfunction : merge

  assign wr_merged = merge(read_mux, AVS_WRITEDATA, AVS_BYTEENABLE);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Every access waits exactly one cycle; read data is latched in that cycle.
    wr_hit        = AVS_WRITE && s.served;
    next_s.served = (AVS_READ || AVS_WRITE) && !s.served;
    if (AVS_READ && !s.served) begin
      next_s.rdata = read_mux;
    end
    if (wr_hit) begin
      unique case (AVS_ADDRESS)
        mcd_pkg::OFS_CUR_GAIN:     next_s.cur_gain     = wr_merged;
        mcd_pkg::OFS_CHG_GAIN:     next_s.chg_gain     = wr_merged;
        mcd_pkg::OFS_CELL_OFFSET:  next_s.cell_offset  = wr_merged[15:0];
        mcd_pkg::OFS_DIV_OFFSET:   next_s.div_offset   = wr_merged[15:0];
        mcd_pkg::OFS_OFFSET_CONVS: next_s.offset_convs = wr_merged[15:0];
        mcd_pkg::OFS_BOARD_OFFSET: next_s.board_offset = wr_merged[15:0];
        mcd_pkg::OFS_INT_OFFSET:   next_s.int_offset   = wr_merged[7:0];
        mcd_pkg::OFS_INT_GAIN:     next_s.int_gain     = wr_merged[15:0];
        mcd_pkg::OFS_INT_BASE:     next_s.int_base     = wr_merged[15:0];
        mcd_pkg::OFS_INT_MAX_AD:   next_s.int_max_ad   = wr_merged[15:0];
        mcd_pkg::OFS_INT_MAX_TEMP: next_s.int_max_temp = wr_merged[15:0];
        mcd_pkg::OFS_PIN_MODE: begin
          next_s.pin_therm = wr_merged[mcd_pkg::POS_PIN_THERM +: mcd_pkg::NUM_PINS];
          next_s.pin_poly  = wr_merged[mcd_pkg::POS_PIN_POLY +: mcd_pkg::NUM_PINS];
        end
        mcd_pkg::OFS_PIN_OFFSET, mcd_pkg::OFS_PIN_OFFSET + 8'h04,
        mcd_pkg::OFS_PIN_OFFSET + 8'h08: begin
          for (int i = 0; i < mcd_pkg::NUM_PINS; i++) begin
            if (AVS_ADDRESS == mcd_pkg::OFS_PIN_OFFSET + 8'(4 * (i / 4))
                && AVS_BYTEENABLE[i % 4]) begin
              next_s.pin_offset[i] = AVS_WRITEDATA[8 * (i % 4) +: 8];
            end
          end
        end
        default: begin
          next_s.served = 1'b0;
        end
      endcase
    end
    // Software may still trim the charge gain alone after the reload.
    if (wr_hit && AVS_ADDRESS == mcd_pkg::OFS_CUR_GAIN) begin
      next_s.chg_gain = chg_from_cur;
    end
    // Dividing the stored settings afresh every cycle, not once per change, avoids drift from repeated rounding.
    next_s.board_quot = s.board_offset[15] ? 32'(-quot_mag) : quot_mag;

    next_s.cell_valid = CELL_IN_VALID;
    if (CELL_IN_VALID) begin
      next_s.cell_index = CELL_IN_INDEX;
      next_s.cell_mv    = 17'(CELL_IN_MV) - 17'(s.cell_offset);
    end
    next_s.div_valid = DIV_IN_VALID;
    if (DIV_IN_VALID) begin
      next_s.div_sel  = DIV_IN_SEL;
      next_s.div_volt = 17'(DIV_IN_VOLT) - 17'(s.div_offset);
    end
    next_s.cc_valid = CC_IN_VALID;
    if (CC_IN_VALID) begin
      next_s.cc_current = cur_scaled;
      next_s.cc_charge  = chg_scaled;
    end
    next_s.int_valid = INT_IN_VALID;
    if (INT_IN_VALID) begin
      next_s.int_sat = INT_IN_RAW > s.int_max_ad;
      next_s.int_temp = (INT_IN_RAW > s.int_max_ad) ? 32'(s.int_max_temp)
                                                    : int_calc;
    end
    next_s.pin_valid = PIN_IN_VALID;
    if (PIN_IN_VALID) begin
      next_s.pin_index = PIN_IN_INDEX;
      next_s.pin_temp  = 17'(PIN_IN_TEMP) + 17'(pin_adjust);
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s              <= '0;
      s.cur_gain     <= mcd_pkg::RST_CUR_GAIN;
      s.chg_gain     <= mcd_pkg::RST_CHG_GAIN;
      s.cell_offset  <= mcd_pkg::RST_CELL_OFFSET;
      s.div_offset   <= mcd_pkg::RST_DIV_OFFSET;
      s.offset_convs <= mcd_pkg::RST_OFFSET_CONVS;
      s.board_offset <= mcd_pkg::RST_BOARD_OFFSET;
      s.int_offset   <= mcd_pkg::RST_INT_OFFSET;
      s.int_gain     <= mcd_pkg::RST_INT_GAIN;
      s.int_base     <= mcd_pkg::RST_INT_BASE;
      s.int_max_ad   <= mcd_pkg::RST_INT_MAX_AD;
      s.int_max_temp <= mcd_pkg::RST_INT_MAX_TEMP;
      s.pin_offset   <= {mcd_pkg::NUM_PINS{mcd_pkg::RST_PIN_OFFSET}};
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign AVS_WAITREQUEST   = (AVS_READ || AVS_WRITE) && !s.served;
  assign AVS_READDATA      = s.rdata;
  assign CELL_OUT_VALID    = s.cell_valid;
  assign CELL_OUT_INDEX    = s.cell_index;
  assign CELL_OUT_MV       = s.cell_mv;
  assign DIV_OUT_VALID     = s.div_valid;
  assign DIV_OUT_SEL       = s.div_sel;
  assign DIV_OUT_VOLT      = s.div_volt;
  assign CC_OUT_VALID      = s.cc_valid;
  assign CC_OUT_CURRENT    = s.cc_current;
  assign CC_OUT_CHARGE     = s.cc_charge;
  assign INT_OUT_VALID     = s.int_valid;
  assign INT_OUT_TEMP      = s.int_temp;
  assign INT_OUT_SATURATED = s.int_sat;
  assign PIN_OUT_VALID     = s.pin_valid;
  assign PIN_OUT_INDEX     = s.pin_index;
  assign PIN_OUT_TEMP      = s.pin_temp;

endmodule : mcd_calib

/* File: sim/mcd_calib_asserts.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checks
// ----------------------------------------------------------------------------
module mcd_calib_asserts (
  input wire logic        SYS_CLK,
  input wire logic        ARST_N,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        CELL_IN_VALID,
  input wire logic        CELL_OUT_VALID,
  input wire logic [16:0] CELL_OUT_MV,
  input wire logic        DIV_IN_VALID,
  input wire logic        DIV_OUT_VALID,
  input wire logic        CC_IN_VALID,
  input wire logic        CC_OUT_VALID,
  input wire logic        INT_IN_VALID,
  input wire logic        INT_OUT_VALID,
  input wire logic        INT_OUT_SATURATED,
  input wire logic        PIN_IN_VALID,
  input wire logic        PIN_OUT_VALID
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  a_cell_lat: assert property (CELL_OUT_VALID == $past(CELL_IN_VALID))
    else $error("cell result not one cycle after sample");
  a_div_lat: assert property (DIV_OUT_VALID == $past(DIV_IN_VALID))
    else $error("divider result not one cycle after sample");
  a_cc_lat: assert property (CC_IN_VALID |=> CC_OUT_VALID)
    else $error("current result missing");
  a_int_lat: assert property (INT_OUT_VALID == $past(INT_IN_VALID))
    else $error("internal temperature result not one cycle after sample");
  a_pin_lat: assert property (PIN_IN_VALID |=> PIN_OUT_VALID)
    else $error("pin temperature result missing");
  a_sat_hold: assert property (!INT_OUT_VALID |-> $stable(INT_OUT_SATURATED))
    else $error("saturation flag moved without a sample");
  a_cell_hold: assert property (!CELL_OUT_VALID |-> $stable(CELL_OUT_MV))
    else $error("cell result moved without a sample");
  // A held request must be answered on the next cycle, so settings never stall.
  a_bus_answer: assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus request not answered in one cycle");
endmodule : mcd_calib_asserts

bind mcd_calib mcd_calib_asserts chk_u (.SYS_CLK, .ARST_N, .AVS_READ, .AVS_WRITE,
  .AVS_WAITREQUEST, .CELL_IN_VALID, .CELL_OUT_VALID, .CELL_OUT_MV, .DIV_IN_VALID,
  .DIV_OUT_VALID, .CC_IN_VALID, .CC_OUT_VALID, .INT_IN_VALID, .INT_OUT_VALID,
  .INT_OUT_SATURATED, .PIN_IN_VALID, .PIN_OUT_VALID);

/* File: sim/mcd_calib_tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Bench
// ----------------------------------------------------------------------------
module mcd_calib_tb_top;
  logic        SYS_CLK = 1'b0;
  logic        ARST_N  = 1'b0;
  logic        rd = 1'b0, wr = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, din = 32'h0, q;
  logic [4:0]  iv = 5'h00;
  logic [3:0]  ix = 4'h0;
  int          fail_count = 0, n_tests = 0, cyc = 0;
  wire [31:0]  rdat, itemp;
  wire         wreq, sat;
  wire [4:0]   ov;
  wire [3:0]   cix, pix;
  wire [1:0]   dsel;
  wire signed [16:0] cmv, dvo, ptemp;
  wire signed [47:0] cur, chg;
  localparam logic [7:0]  RA [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20,
                                      8'h24, 8'h28, 8'h40};
  localparam logic [31:0] RV [10] = '{32'h40EF41F2, 32'h4A081C6A, 0, 0, 32'h40, 32'h632E,
                                      32'h0BD8, 32'h3FFF, 32'h18EB, 0};
  always #2.5 SYS_CLK = ~SYS_CLK;
  mcd_calib dut_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .CELL_IN_VALID(iv[0]), .CELL_IN_INDEX(ix), .CELL_IN_MV(din[15:0]),
    .DIV_IN_VALID(iv[1]), .DIV_IN_SEL(ix[1:0]), .DIV_IN_VOLT(din[15:0]), .CC_IN_VALID(iv[2]),
    .CC_IN_COUNT(din), .INT_IN_VALID(iv[3]), .INT_IN_RAW(din[15:0]), .PIN_IN_VALID(iv[4]),
    .PIN_IN_INDEX(ix), .PIN_IN_TEMP(din[15:0]), .CELL_OUT_VALID(ov[0]), .CELL_OUT_INDEX(cix),
    .CELL_OUT_MV(cmv), .DIV_OUT_VALID(ov[1]), .DIV_OUT_SEL(dsel), .DIV_OUT_VOLT(dvo),
    .CC_OUT_VALID(ov[2]), .CC_OUT_CURRENT(cur), .CC_OUT_CHARGE(chg), .INT_OUT_VALID(ov[3]),
    .INT_OUT_TEMP(itemp), .INT_OUT_SATURATED(sat), .PIN_OUT_VALID(ov[4]),
    .PIN_OUT_INDEX(pix), .PIN_OUT_TEMP(ptemp));
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // The request is held until waitrequest is seen low at a rising edge.
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    adr <= a;
    wd  <= d;
    rd  <= !w;
    wr  <= w;
    @(posedge SYS_CLK iff wreq === 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask : rchk
  // One sample on stream k; results are read at the falling edge, once settled.
  task automatic push(input int k, input logic [3:0] i, input logic [31:0] v);
    @(posedge SYS_CLK);
    iv  <= 5'h01 << k;
    ix  <= i;
    din <= v;
    @(posedge SYS_CLK);
    iv <= 5'h00;
    @(negedge SYS_CLK);
    chk("valid", 5'h01 << k, ov);
  endtask : push
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (4) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    foreach (RA[i]) begin
      rchk("rst", RA[i], RV[i]);
    end
    rchk("status", 8'h3C, 32'h0);
    av(1'b1, 8'h08, 32'hFFFB);
    push(0, 4'h3, 32'd100);
    chk("cell_mv", 105, cmv);
    chk("cell_index", 3, cix);
    av(1'b1, 8'h08, 32'h7FFF);
    push(0, 4'h0, 32'hFFFF8000);
    chk("cell_mv", -65535, cmv);
    av(1'b1, 8'h0C, 32'h000A);
    for (int i = 0; i < 3; i++) begin
      push(1, 4'(i), 32'hFFFFFFEC);
      chk("div_volt", -30, dvo);
      chk("div_sel", i, dsel);
    end
    push(3, 4'h0, 32'd16383);
    chk("int_temp", 16383 * 25390 / 65536 + 3032, itemp);
    chk("int_sat", 0, sat);
    av(1'b1, 8'h18, 32'hFD);
    push(3, 4'h0, 32'd16383);
    chk("int_temp", 16383 * 25390 / 65536 + 3029, itemp);
    push(3, 4'h0, 32'd16384);
    chk("int_temp", 6379, itemp);
    chk("int_sat", 1, sat);
    // Pin 5 is an analog input and pin 2 has no polynomial; index 9 has no pin.
    av(1'b1, 8'h2C, 32'h01FB01DF);
    av(1'b1, 8'h30, 32'h04030201);
    av(1'b1, 8'h34, 32'h08070605);
    av(1'b1, 8'h38, 32'h09);
    for (int i = 0; i < 10; i++) begin
      push(4, 4'(i), 32'd250);
      chk("pin_temp", 250 + ((i < 9 && i != 2 && i != 5) ? i + 1 : 0), ptemp);
      chk("pin_index", i, pix);
    end
    av(1'b1, 8'h00, 32'h3F800000);
    rchk("charge_gain", 8'h04, mcd_pkg::CHG_PER_CUR);
    av(1'b1, 8'h14, 32'h1);
    av(1'b1, 8'h10, 32'h3);
    push(2, 4'h0, 32'd10);
    chk("current", (655360 - 65536 / 3) / 256, cur);
    // Gain is significand times 2^-5; ten counts in Q8 give significand times 80.
    chk("charge", {1'b1, mcd_pkg::CHG_PER_CUR[22:0]} * 80, chg);
    av(1'b1, 8'h10, 32'h0);
    rchk("status", 8'h3C, 32'h3);
    push(2, 4'h0, 32'd10);
    chk("current", 2560, cur);
    finish_test();
  end
endmodule : mcd_calib_tb_top
